// File: logic/acs_sequencer.sv
// top of the converter sequencer control block with register port
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int RESULT_WIDTH = 12
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [RESULT_WIDTH-1:0] conv_data_in,
    input wire logic [7:0] port_dir_in,
    input wire logic [7:0] pullup_cfg,
    output logic conv_reset,
    output logic conv_active,
    output logic conv_sample,
    output logic [8:0] channel_onehot,
    output logic [7:0] pin_analog,
    output logic [7:0] pin_dir_in,
    output logic [7:0] pin_pullup_on,
    output logic internal_analog_channel,
    output logic conv_irq
);
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_HELD = 2'b01,
        ACS_RUN = 2'b10
    } acs_state_t;

    acs_state_t state_r;
    logic start_r;
    logic busy_r;
    logic [3:0] chan_r;
    logic [1:0] div_r;
    logic [6:0] pinl_r;
    logic [1:0] pinh_r;
    logic master_ie_r;
    logic conv_ie_r;
    logic conv_req_r;
    logic [4:0] period_cnt_r;
    logic [RESULT_WIDTH-1:0] result_r;
    logic [7:0] reg_rdata_r;
    logic period_tick;
    logic conv_done;
    logic start_rise;
    logic start_fall;
    logic wr_control;
    logic wr_irq;
    logic wr_clock;
    logic wr_pin_low;
    logic wr_pin_high;
    logic conv_abort;
    logic period_last;
    logic irq_enabled;
    // next values of the sequence and bus registers
    acs_state_t state_nxt;
    logic busy_nxt;
    logic [4:0] period_cnt_nxt;
    logic conv_req_nxt;
    logic [7:0] reg_rdata_nxt;
    // register views seen by the read port
    logic [7:0] view_control;
    logic [7:0] view_clock;
    logic [7:0] view_pin_low;
    logic [7:0] view_pin_high;
    logic [7:0] view_result_low;
    logic [7:0] view_result_high;
    logic [7:0] view_irq;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // bus write decodes
    assign wr_control = reg_write && hit(reg_addr, ACS_OFF_CONV_CONTROL);
    assign wr_clock = reg_write && hit(reg_addr, ACS_OFF_CLOCK_SELECT);
    assign wr_pin_low = reg_write && hit(reg_addr, ACS_OFF_PIN_LOW);
    assign wr_pin_high = reg_write && hit(reg_addr, ACS_OFF_PIN_HIGH);
    assign wr_irq = reg_write && hit(reg_addr, ACS_OFF_IRQ_CONTROL);

    // start pulse edges
    assign start_rise = wr_control && reg_wdata[ACS_BIT_START] && !start_r;
    assign start_fall = wr_control && !reg_wdata[ACS_BIT_START] && start_r;
    assign conv_abort = start_rise && (state_r == ACS_RUN);

    // end of the sixteenth converter clock period
    assign period_last = (period_cnt_r == ACS_CONV_PERIODS - 5'h01);
    assign conv_done = (state_r == ACS_RUN) && period_tick && period_last;
    assign irq_enabled = conv_ie_r && master_ie_r;

    acs_clock_div u_div (
        .clk(clk),
        .reset_n(reset_n),
        .run(state_r == ACS_RUN),
        .conv_clock_divider_field(div_r),
        .period_tick(period_tick)
    );

    acs_pin_mux u_mux (
        .pin_analog_enables_low(pinl_r),
        .pin_analog_enable_8(pinh_r[0]),
        .internal_channel_enable(pinh_r[1]),
        .channel_select_field(chan_r),
        .port_dir_in(port_dir_in),
        .pullup_cfg(pullup_cfg),
        .pin_analog(pin_analog),
        .pin_dir_in(pin_dir_in),
        .pin_pullup_on(pin_pullup_on),
        .internal_analog_channel(internal_analog_channel),
        .channel_onehot(channel_onehot),
        .channel_valid()
    );

    // start bit, reads back as written
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            start_r <= 1'b0;
        end else if (wr_control) begin
            start_r <= reg_wdata[ACS_BIT_START];
        end
    end

    // channel select field
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_r <= ACS_CHAN_RESET;
        end else if (wr_control) begin
            chan_r <= reg_wdata[3:0];
        end
    end

    // converter clock divider field
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= ACS_DIV_RESET;
        end else if (wr_clock) begin
            div_r <= reg_wdata[1:0];
        end
    end

    // low pin analog enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinl_r <= ACS_PINL_RESET;
        end else if (wr_pin_low) begin
            pinl_r <= reg_wdata[7:1];
        end
    end

    // high pin analog enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinh_r <= ACS_PINH_RESET;
        end else if (wr_pin_high) begin
            pinh_r <= reg_wdata[1:0];
        end
    end

    // interrupt enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            master_ie_r <= 1'b0;
            conv_ie_r <= 1'b0;
        end else if (wr_irq) begin
            master_ie_r <= reg_wdata[ACS_BIT_MASTER_IE];
            conv_ie_r <= reg_wdata[ACS_BIT_CONV_IE];
        end
    end

    // next state of the conversion sequence
    always_comb begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        period_cnt_nxt = period_cnt_r;
        unique case (state_r)
            ACS_IDLE: begin
                if (start_rise) begin
                    state_nxt = ACS_HELD;
                    busy_nxt = 1'b1;
                end
            end
            ACS_HELD: begin
                busy_nxt = 1'b1;
                if (start_fall) begin
                    state_nxt = ACS_RUN;
                    period_cnt_nxt = 5'h00;
                end
            end
            ACS_RUN: begin
                if (conv_abort) begin
                    state_nxt = ACS_HELD;
                    busy_nxt = 1'b1;
                end else if (conv_done) begin
                    state_nxt = ACS_IDLE;
                    busy_nxt = 1'b0;
                end else if (period_tick) begin
                    period_cnt_nxt = period_cnt_r + 5'h01;
                end
            end
            default: begin
                state_nxt = ACS_IDLE;
            end
        endcase
    end

    // sequence state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ACS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // busy flag, one after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b1;
        end else begin
            busy_r <= busy_nxt;
        end
    end

    // converter period counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_cnt_r <= 5'h00;
        end else begin
            period_cnt_r <= period_cnt_nxt;
        end
    end

    // result capture at the end of conversion
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_r <= '0;
        end else if (conv_done) begin
            result_r <= conv_data_in;
        end
    end

    // request flag; set wins over software clear
    always_comb begin
        conv_req_nxt = conv_req_r;
        if (conv_done) begin
            conv_req_nxt = 1'b1;
        end else if (wr_irq) begin
            conv_req_nxt = reg_wdata[ACS_BIT_CONV_REQ];
        end
    end

    // request flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_req_r <= 1'b0;
        end else begin
            conv_req_r <= conv_req_nxt;
        end
    end

    // register read views; unused bits read zero
    assign view_control = {start_r, busy_r, 2'h0, chan_r};
    assign view_clock = {6'h00, div_r};
    assign view_pin_low = {pinl_r, 1'h0};
    assign view_pin_high = {6'h00, pinh_r};
    assign view_result_low = {result_r[3:0], 4'h0};
    assign view_result_high = result_r[11:4];
    assign view_irq = {5'h00, conv_req_r, conv_ie_r, master_ie_r};

    // read data select, zero outside a read
    always_comb begin
        reg_rdata_nxt = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                ACS_OFF_CONV_CONTROL: begin
                    reg_rdata_nxt = view_control;
                end
                ACS_OFF_CLOCK_SELECT: begin
                    reg_rdata_nxt = view_clock;
                end
                ACS_OFF_PIN_LOW: begin
                    reg_rdata_nxt = view_pin_low;
                end
                ACS_OFF_PIN_HIGH: begin
                    reg_rdata_nxt = view_pin_high;
                end
                ACS_OFF_RESULT_LOW: begin
                    reg_rdata_nxt = view_result_low;
                end
                ACS_OFF_RESULT_HIGH: begin
                    reg_rdata_nxt = view_result_high;
                end
                ACS_OFF_IRQ_CONTROL: begin
                    reg_rdata_nxt = view_irq;
                end
                default: begin
                    reg_rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign conv_reset = (state_r == ACS_HELD);
    assign conv_active = (state_r == ACS_RUN);
    assign conv_sample = conv_done;
    assign conv_irq = conv_req_r && irq_enabled;
endmodule : acs_sequencer
`default_nettype wire

// File: logic/acs_pkg.sv
// constants for the converter sequencer control block
package acs_pkg;
    localparam logic [7:0] ACS_OFF_CONV_CONTROL = 8'h00;
    localparam logic [7:0] ACS_OFF_CLOCK_SELECT = 8'h01;
    localparam logic [7:0] ACS_OFF_PIN_LOW = 8'h02;
    localparam logic [7:0] ACS_OFF_PIN_HIGH = 8'h03;
    localparam logic [7:0] ACS_OFF_RESULT_LOW = 8'h04;
    localparam logic [7:0] ACS_OFF_RESULT_HIGH = 8'h05;
    localparam logic [7:0] ACS_OFF_IRQ_CONTROL = 8'h06;
    localparam int ACS_BIT_START = 7;
    localparam int ACS_BIT_BUSY = 6;
    localparam int ACS_BIT_MASTER_IE = 0;
    localparam int ACS_BIT_CONV_IE = 1;
    localparam int ACS_BIT_CONV_REQ = 2;
    localparam logic [3:0] ACS_CHAN_RESET = 4'h0;
    localparam logic [1:0] ACS_DIV_RESET = 2'h0;
    localparam logic [6:0] ACS_PINL_RESET = 7'h00;
    localparam logic [1:0] ACS_PINH_RESET = 2'h0;
    localparam logic [3:0] ACS_CHAN_FIRST = 4'h1;
    localparam logic [3:0] ACS_CHAN_INTERNAL = 4'h9;
    localparam logic [1:0] ACS_DIV_2 = 2'h0;
    localparam logic [1:0] ACS_DIV_8 = 2'h1;
    localparam logic [1:0] ACS_DIV_32 = 2'h2;
    localparam logic [4:0] ACS_HALF_2 = 5'h00;
    localparam logic [4:0] ACS_HALF_8 = 5'h03;
    localparam logic [4:0] ACS_HALF_32 = 5'h0F;
    localparam logic [4:0] ACS_CONV_PERIODS = 5'h10;
endpackage : acs_pkg

// File: logic/acs_clock_div.sv
// converter clock divider producing one tick per converter clock period
`timescale 1ns/1ps
`default_nettype none
module acs_clock_div
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [1:0] conv_clock_divider_field,
    output logic period_tick
);
    logic [4:0] half_r;
    logic phase_r;
    logic [4:0] limit;
    always_comb begin
        unique case (conv_clock_divider_field)
            ACS_DIV_2: limit = ACS_HALF_2;
            ACS_DIV_8: limit = ACS_HALF_8;
            ACS_DIV_32: limit = ACS_HALF_32;
            default: limit = ACS_HALF_32;
        endcase
    end
    // counts half periods; tick at the end of each full period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_r <= 5'h00;
            phase_r <= 1'b0;
        end else if (!run) begin
            half_r <= 5'h00;
            phase_r <= 1'b0;
        end else if (half_r >= limit) begin
            half_r <= 5'h00;
            phase_r <= ~phase_r;
        end else begin
            half_r <= half_r + 5'h01;
        end
    end
    assign period_tick = run && phase_r && (half_r >= limit);
endmodule : acs_clock_div
`default_nettype wire

// File: logic/acs_pin_mux.sv
// analog pin function selection and channel decode
`timescale 1ns/1ps
`default_nettype none
module acs_pin_mux
    import acs_pkg::*;
(
    input wire logic [6:0] pin_analog_enables_low,
    input wire logic pin_analog_enable_8,
    input wire logic internal_channel_enable,
    input wire logic [3:0] channel_select_field,
    input wire logic [7:0] port_dir_in,
    input wire logic [7:0] pullup_cfg,
    output logic [7:0] pin_analog,
    output logic [7:0] pin_dir_in,
    output logic [7:0] pin_pullup_on,
    output logic internal_analog_channel,
    output logic [8:0] channel_onehot,
    output logic channel_valid
);
    assign pin_analog = {pin_analog_enable_8, pin_analog_enables_low};
    assign internal_analog_channel = internal_channel_enable;
    assign pin_pullup_on = pullup_cfg & ~pin_analog;
    assign pin_dir_in = port_dir_in | pin_analog;
    assign channel_valid = (channel_select_field >= ACS_CHAN_FIRST)
        && (channel_select_field <= ACS_CHAN_INTERNAL);
    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_chan
            assign channel_onehot[g] = channel_valid
                && (channel_select_field == 4'(g + 1));
        end
    endgenerate
endmodule : acs_pin_mux
`default_nettype wire

// File: test/acs_sequencer_asserts.sv
// concurrent checks on the converter sequencer control block ports
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_asserts
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] port_dir_in,
    input wire logic [7:0] pullup_cfg,
    input wire logic conv_reset,
    input wire logic conv_active,
    input wire logic conv_sample,
    input wire logic [8:0] channel_onehot,
    input wire logic [7:0] pin_analog,
    input wire logic [7:0] pin_dir_in,
    input wire logic [7:0] pin_pullup_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [9:0] act_cnt_r;
    // cycles spent converting so far
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) act_cnt_r <= 10'h000;
        else act_cnt_r <= conv_active ? act_cnt_r + 10'h001 : 10'h000;
    end
    property p_pu; pin_pullup_on == (pullup_cfg & ~pin_analog); endproperty
    a_pu: assert property (p_pu) else $error("pull-up kept on analog pin");
    property p_dir; pin_dir_in == (port_dir_in | pin_analog); endproperty
    a_dir: assert property (p_dir) else $error("analog pin not forced to input");
    property p_rst; reg_read && reg_addr == ACS_OFF_CONV_CONTROL && conv_reset
        |=> reg_rdata[ACS_BIT_BUSY]; endproperty
    a_rst: assert property (p_rst) else $error("busy low while held in reset");
    property p_start; $fell(conv_reset) |-> ##[0:2] conv_active; endproperty
    a_start: assert property (p_start) else $error("no conversion after start pulse");
    property p_len; conv_sample |-> act_cnt_r inside {[10'h01C:10'h024],
        [10'h07C:10'h084], [10'h1FC:10'h204]}; endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_clr; conv_sample |=> !conv_active; endproperty
    a_clr: assert property (p_clr) else $error("busy not cleared at end");
    property p_hot; $onehot0(channel_onehot); endproperty
    a_hot: assert property (p_hot) else $error("more than one channel selected");
    property p_bound; act_cnt_r < 10'h208; endproperty
    a_bound: assert property (p_bound) else $error("conversion never ends");
    c_end: cover property (conv_sample);
    c_start: cover property ($fell(conv_reset));
    c_hold: cover property (conv_reset ##1 conv_reset);
endmodule : acs_sequencer_asserts
bind acs_sequencer acs_sequencer_asserts acs_sequencer_asserts_inst (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_dir_in(port_dir_in), .pullup_cfg(pullup_cfg),
    .conv_reset(conv_reset), .conv_active(conv_active), .conv_sample(conv_sample),
    .channel_onehot(channel_onehot), .pin_analog(pin_analog), .pin_dir_in(pin_dir_in),
    .pin_pullup_on(pin_pullup_on));
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import acs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port_dir_in = 8'h00, pullup_cfg = 8'h00;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic [11:0] conv_data_in = 12'h000;
    logic [7:0] reg_rdata, pin_analog, pin_dir_in, pin_pullup_on;
    logic [8:0] channel_onehot;
    logic conv_reset, conv_active, conv_sample, internal_analog_channel, conv_irq;
    int mismatches = 0, cmp_count = 0, n, e, pl, ph, r;
    int exp_q[$];
    always #5 clk = ~clk;
    acs_sequencer acs_sequencer_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .conv_data_in(conv_data_in), .port_dir_in(port_dir_in),
        .pullup_cfg(pullup_cfg), .conv_reset(conv_reset), .conv_active(conv_active),
        .conv_sample(conv_sample), .channel_onehot(channel_onehot), .pin_analog(pin_analog),
        .pin_dir_in(pin_dir_in), .pin_pullup_on(pin_pullup_on),
        .internal_analog_channel(internal_analog_channel), .conv_irq(conv_irq));
    task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        cmp("reg_rdata", reg_rdata, exp);
    endtask : rc
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h1413));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rc(ACS_OFF_CONV_CONTROL, 8'h40);
        for (int a = 1; a < 4; a++) rc(8'(a), 8'h00);
        rc(8'h07, 8'h00);
        pl = $urandom;
        ph = $urandom;
        port_dir_in <= 8'($urandom);
        pullup_cfg <= 8'($urandom);
        wr(ACS_OFF_PIN_LOW, 8'(pl));
        wr(ACS_OFF_PIN_HIGH, 8'(ph));
        rc(ACS_OFF_PIN_LOW, 8'(pl) & 8'hFE);
        rc(ACS_OFF_PIN_HIGH, 8'(ph) & 8'h03);
        cmp("pin_analog", pin_analog, {ph[0], pl[7:1]});
        cmp("internal", internal_analog_channel, ph[1]);
        cmp("pullup", pin_pullup_on, pullup_cfg & ~{ph[0], pl[7:1]});
        cmp("dir", pin_dir_in, port_dir_in | {ph[0], pl[7:1]});
        for (int c = 0; c < 16; c++) begin
            wr(ACS_OFF_CONV_CONTROL, 8'(c));
            cmp("onehot", channel_onehot, (c >= 1 && c <= 9) ? 32'(1) << (c - 1) : 0);
        end
        wr(ACS_OFF_CONV_CONTROL, 8'h31);
        rc(ACS_OFF_CONV_CONTROL, 8'h41);
        for (int d = 0; d < 4; d++) begin
            wr(ACS_OFF_CLOCK_SELECT, 8'(d));
            rc(ACS_OFF_CLOCK_SELECT, 8'(d));
            wr(ACS_OFF_IRQ_CONTROL, 8'(d));
            conv_data_in <= 12'($urandom);
            wr(ACS_OFF_CONV_CONTROL, 8'h80 | 8'(d >> 1));
            exp_q.push_back(int'(conv_data_in));
            rc(ACS_OFF_CONV_CONTROL, 8'hC0 | 8'(d >> 1));
            cmp("conv_reset", conv_reset, 1'b1);
            wr(ACS_OFF_CONV_CONTROL, 8'(d >> 1));
            n = 0;
            while (conv_sample !== 1'b1 && n < 600) begin
                @(posedge clk);
                #1;
                n++;
            end
            e = 16 * ((d == 0) ? 2 : (d == 1) ? 8 : 32);
            cmp("conv_len", n >= e - 4 && n <= e + 4, 1'b1);
            rc(ACS_OFF_CONV_CONTROL, 8'(d >> 1));
            r = exp_q.pop_front();
            rc(ACS_OFF_RESULT_HIGH, 8'(r >> 4));
            rc(ACS_OFF_RESULT_LOW, {r[3:0], 4'h0});
            rc(ACS_OFF_IRQ_CONTROL, 8'(d) | 8'h04);
            cmp("conv_irq", conv_irq, d == 3);
            wr(ACS_OFF_IRQ_CONTROL, 8'(d));
            cmp("irq_clear", conv_irq, 1'b0);
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
